// ### nls_pkg.sv
// Package holding the register map and field layout of the network link status bank
//
// Functional notes
// (R01) Field channels two to seven share channel one command and status layout.
// (R02) Sixteen scan error words cover link words 0-255; bit set when not refreshed.
// (R03) Lowest link word maps to bit 0 of first error word, ascending.
// (R04) Station status test-mode flag set while station in test mode.
// (R05) Station master flag set when master, clear when slave.
// (R06) Scan-inhibit flag set while scan transmission inhibited.
// (R07) Bits C-F show online, standby, offline, down modes.
// (R08) Station status bits 1-3 and 6-B are reserved, read zero.
// (R09) Four online words and four standby words per channel cover stations 1-64.
// (R10) Lowest station number maps to bit 0 of first map word.
// (R11) Sixty-four healthy words cover link area words 0-1023; bit set when refreshed.
// (R12) Lowest link area word maps to bit 0 of first healthy word.
// (R13) Channel stops transmission while transmission-stop command bit held set.
// (R14) Channel enters output inhibit while output-inhibit command bit held set.
// (R15) Channel transmission status bit set while transmitting.
// (R16) Channel scan-error status bit set when scan transmission error occurs.
// (R17) Status and maps are read-only, refreshed at least once per controller scan.
`default_nettype none
package nls_pkg;
  localparam int NLS_FIELD_CH   = 7;
  localparam int NLS_ERR_WORDS  = 16;
  localparam int NLS_STN_CH     = 2;
  localparam int NLS_MAP_WORDS  = 4;
  localparam int NLS_HLT_WORDS  = 64;
  // Word indices; byte address is four times the index
  localparam logic [7:0] NLS_IDX_FIELD_BASE = 8'h50;
  localparam logic [7:0] NLS_IDX_ERR_BASE   = 8'h5E;
  localparam logic [7:0] NLS_IDX_STN_BASE   = 8'h6E;
  localparam logic [7:0] NLS_IDX_ONL_BASE   = 8'h70;
  localparam logic [7:0] NLS_IDX_STB_BASE   = 8'h78;
  localparam logic [7:0] NLS_IDX_HLT_BASE   = 8'h80;
  localparam logic [7:0] NLS_IDX_SCAN_CTL   = 8'hC0;
  // Command word fields
  localparam int NLS_CMD_TXSTOP  = 8;
  localparam int NLS_CMD_OUTINH  = 9;
  localparam logic [15:0] NLS_CMD_MASK  = 16'h0300;
  localparam logic [15:0] NLS_CMD_RESET = 16'h0000;
  // Channel status fields
  localparam int NLS_ST_TX       = 0;
  localparam int NLS_ST_OUTINH   = 1;
  localparam int NLS_ST_RECONF   = 2;
  localparam int NLS_ST_SCANERR  = 4;
  // Station status fields
  localparam int NLS_SS_TEST     = 0;
  localparam int NLS_SS_MASTER   = 4;
  localparam int NLS_SS_SCANINH  = 5;
  localparam int NLS_SS_ONLINE   = 12;
  localparam int NLS_SS_STANDBY  = 13;
  localparam int NLS_SS_OFFLINE  = 14;
  localparam int NLS_SS_DOWN     = 15;
  localparam logic [15:0] NLS_SS_RSVD_MASK = 16'h0FCE;
endpackage : nls_pkg
`default_nettype wire

// ### nls_status_bank.sv
// Network link status and command register bank with classic Wishbone slave
`default_nettype none
module nls_status_bank
  import nls_pkg::*;
#(
  parameter int NUM_FIELD_CH = NLS_FIELD_CH
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         wb_cyc_i,
  input  wire logic         wb_stb_i,
  input  wire logic         wb_we_i,
  input  wire logic [9:0]   wb_adr_i,
  input  wire logic [3:0]   wb_sel_i,
  input  wire logic [31:0]  wb_dat_i,
  output logic      [31:0]  wb_dat_o,
  output logic              wb_ack_o,
  input  wire logic         scan_strobe,
  input  wire logic [6:0]   field_tx_active,
  input  wire logic [6:0]   field_out_inh_active,
  input  wire logic [6:0]   field_reconfig,
  input  wire logic [6:0]   field_scan_err,
  output logic      [6:0]   field_tx_stop,
  output logic      [6:0]   field_out_inhibit,
  input  wire logic [255:0] link_word_area_fail,
  input  wire logic [1:0]   stn_test_mode,
  input  wire logic [1:0]   stn_master,
  input  wire logic [1:0]   stn_scan_inhibit,
  input  wire logic [1:0]   stn_online,
  input  wire logic [1:0]   stn_standby,
  input  wire logic [1:0]   stn_offline,
  input  wire logic [1:0]   stn_down,
  input  wire logic [127:0] stn_online_map,
  input  wire logic [127:0] stn_standby_map,
  input  wire logic [1023:0] link_area_healthy,
  output logic              scan_done
);
  if (NUM_FIELD_CH != NLS_FIELD_CH) begin : g_chk
    $error("nls_status_bank: channel count fixed at seven");
  end

  logic [15:0]   cmd_q [NLS_FIELD_CH];
  logic [15:0]   chst_q [NLS_FIELD_CH];
  logic [255:0]  err_q;
  logic [15:0]   ss_q [NLS_STN_CH];
  logic [127:0]  onl_q;
  logic [127:0]  stb_q;
  logic [1023:0] hlt_q;
  logic [15:0]   scan_cnt_q;
  logic          refresh_pend_q;
  logic          acc;
  logic [7:0]    idx;
  logic [15:0]   rd_d;

  assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign idx = wb_adr_i[9:2];

  // Single-cycle acknowledge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= acc;
    end
  end

  // (R13) Command words writable
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NLS_FIELD_CH; i++) cmd_q[i] <= NLS_CMD_RESET;
    end else begin
      for (int i = 0; i < NLS_FIELD_CH; i++) begin
        if (acc && wb_we_i && idx == NLS_IDX_FIELD_BASE + 8'(2 * i)) begin
          if (wb_sel_i[0]) cmd_q[i][7:0] <= wb_dat_i[7:0] & NLS_CMD_MASK[7:0];
          if (wb_sel_i[1]) cmd_q[i][15:8] <= wb_dat_i[15:8] & NLS_CMD_MASK[15:8];
        end
      end
    end
  end

  // (R14) Command bits drive channel controls
  always_comb begin
    for (int i = 0; i < NLS_FIELD_CH; i++) begin
      field_tx_stop[i]     = cmd_q[i][NLS_CMD_TXSTOP];
      field_out_inhibit[i] = cmd_q[i][NLS_CMD_OUTINH];
    end
  end

  // Refresh request is scan strobe registered for one cycle; scan_done follows one cycle later
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      refresh_pend_q <= 1'b1;
      scan_cnt_q     <= 16'h0000;
      scan_done      <= 1'b0;
    end else begin
      refresh_pend_q <= scan_strobe;
      scan_done      <= refresh_pend_q;
      if (refresh_pend_q) scan_cnt_q <= scan_cnt_q + 16'h0001;
    end
  end

  // (R17) Status and maps snapshot once per scan
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NLS_FIELD_CH; i++) chst_q[i] <= 16'h0000;
      for (int c = 0; c < NLS_STN_CH; c++) ss_q[c] <= 16'h0000;
      err_q <= '0;
      onl_q <= '0;
      stb_q <= '0;
      hlt_q <= '0;
    end else if (refresh_pend_q) begin
      for (int i = 0; i < NLS_FIELD_CH; i++) begin
        // (R01) Same layout for every channel
        chst_q[i] <= 16'h0000;
        // (R15) Transmission status
        chst_q[i][NLS_ST_TX]      <= field_tx_active[i];
        chst_q[i][NLS_ST_OUTINH]  <= field_out_inh_active[i];
        chst_q[i][NLS_ST_RECONF]  <= field_reconfig[i];
        // (R16) Scan error status
        chst_q[i][NLS_ST_SCANERR] <= field_scan_err[i];
      end
      for (int c = 0; c < NLS_STN_CH; c++) begin
        // (R08) Reserved bits zero
        ss_q[c] <= 16'h0000;
        // (R04) Test mode flag
        ss_q[c][NLS_SS_TEST]    <= stn_test_mode[c];
        // (R05) Master flag
        ss_q[c][NLS_SS_MASTER]  <= stn_master[c];
        // (R06) Scan inhibit flag
        ss_q[c][NLS_SS_SCANINH] <= stn_scan_inhibit[c];
        // (R07) Mode bits C to F
        ss_q[c][NLS_SS_ONLINE]  <= stn_online[c];
        ss_q[c][NLS_SS_STANDBY] <= stn_standby[c];
        ss_q[c][NLS_SS_OFFLINE] <= stn_offline[c];
        ss_q[c][NLS_SS_DOWN]    <= stn_down[c];
      end
      // (R02) Error flags per link word
      err_q <= link_word_area_fail;
      // (R09) Online and standby maps
      onl_q <= stn_online_map;
      stb_q <= stn_standby_map;
      // (R11) Healthy flags per link area word
      hlt_q <= link_area_healthy;
    end
  end

  // Read mux; unmapped words read zero
  always_comb begin
    rd_d = 16'h0000;
    for (int i = 0; i < NLS_FIELD_CH; i++) begin
      if (idx == NLS_IDX_FIELD_BASE + 8'(2 * i)) rd_d = cmd_q[i];
      if (idx == NLS_IDX_FIELD_BASE + 8'(2 * i + 1)) rd_d = chst_q[i];
    end
    // (R03) Ascending bit order
    for (int w = 0; w < NLS_ERR_WORDS; w++) begin
      if (idx == NLS_IDX_ERR_BASE + 8'(w)) rd_d = err_q[16 * w +: 16];
    end
    for (int c = 0; c < NLS_STN_CH; c++) begin
      if (idx == NLS_IDX_STN_BASE + 8'(c)) rd_d = ss_q[c] & ~NLS_SS_RSVD_MASK;
    end
    // (R10) Lowest station at bit 0
    for (int w = 0; w < NLS_STN_CH * NLS_MAP_WORDS; w++) begin
      if (idx == NLS_IDX_ONL_BASE + 8'(w)) rd_d = onl_q[16 * w +: 16];
      if (idx == NLS_IDX_STB_BASE + 8'(w)) rd_d = stb_q[16 * w +: 16];
    end
    // (R12) Lowest word at bit 0
    for (int w = 0; w < NLS_HLT_WORDS; w++) begin
      if (idx == NLS_IDX_HLT_BASE + 8'(w)) rd_d = hlt_q[16 * w +: 16];
    end
    if (idx == NLS_IDX_SCAN_CTL) rd_d = scan_cnt_q;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (acc && !wb_we_i) begin
      wb_dat_o <= {16'h0000, rd_d};
    end
  end
endmodule : nls_status_bank
`default_nettype wire

// ### nls_monitor.sv
// Checker of bus handshake, read data and command outputs
`default_nettype none
module nls_monitor
  import nls_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        scan_strobe,
  input wire logic        scan_done,
  input wire logic [6:0]  field_tx_stop,
  input wire logic [6:0]  field_out_inhibit
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held over one cycle");
  chk_ack_taken: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  chk_read_data_hold: assert property ($changed(wb_dat_o) |-> wb_ack_o && !wb_we_i)
    else $error("read data moved outside a read");
  chk_read_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
    else $error("upper read half not zero");
  chk_scan_done_due: assert property ($rose(scan_strobe) |-> ##[1:3] scan_done)
    else $error("refresh did not complete");
  chk_tx_stop_cause: assert property ($changed(field_tx_stop) |-> wb_ack_o && wb_we_i)
    else $error("stop output moved without write");
  chk_out_inh_cause: assert property ($changed(field_out_inhibit) |-> wb_ack_o && wb_we_i)
    else $error("inhibit output moved without write");
  cover property (wb_ack_o && wb_we_i);
  cover property (wb_ack_o && !wb_we_i);
  cover property (scan_done);
endmodule : nls_monitor
`default_nettype wire

// ### nls_link_model.sv
// Behavioural link modules feeding status into the bank from one index
`default_nettype none
module nls_link_model
  import nls_pkg::*;
(
  input  wire logic          clk,
  input  wire logic [9:0]    n,
  output logic      [6:0]    field_tx_active,
  output logic      [6:0]    field_out_inh_active,
  output logic      [6:0]    field_reconfig,
  output logic      [6:0]    field_scan_err,
  output logic      [255:0]  link_word_area_fail,
  output logic      [1:0]    stn_test_mode,
  output logic      [1:0]    stn_master,
  output logic      [1:0]    stn_scan_inhibit,
  output logic      [1:0]    stn_online,
  output logic      [1:0]    stn_standby,
  output logic      [1:0]    stn_offline,
  output logic      [1:0]    stn_down,
  output logic      [127:0]  stn_online_map,
  output logic      [127:0]  stn_standby_map,
  output logic      [1023:0] link_area_healthy
);
  timeunit 1ns;
  timeprecision 1ns;
  // One marked bit per map so a wrong index shows up
  always_ff @(posedge clk) begin
    {field_tx_active, field_out_inh_active, field_reconfig, field_scan_err} <= {4{n[6:0]}};
    link_word_area_fail <= 256'h1 << n[7:0];
    link_area_healthy   <= 1024'h1 << n;
    stn_online_map      <= 128'h1 << n[6:0];
    stn_standby_map     <= ~(128'h1 << n[6:0]);
    {stn_test_mode, stn_master, stn_scan_inhibit, stn_online} <= {4{n[1:0]}};
    {stn_standby, stn_offline, stn_down} <= {3{~n[1:0]}};
  end
endmodule : nls_link_model
`default_nettype wire

// ### network_link_status_maps_bench.sv
// Testbench of the network link status bank
`default_nettype none
module network_link_status_maps_bench;
  import nls_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, scan_strobe, scan_done;
  logic [9:0] wb_adr_i, n;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [15:0] rd;
  logic [6:0] field_tx_active, field_out_inh_active, field_reconfig, field_scan_err;
  logic [6:0] field_tx_stop, field_out_inhibit;
  logic [1:0] stn_test_mode, stn_master, stn_scan_inhibit, stn_online, stn_standby, stn_offline, stn_down;
  logic [255:0] link_word_area_fail;
  logic [127:0] stn_online_map, stn_standby_map;
  logic [1023:0] link_area_healthy;
  int failures, n_tests, cyc_cnt;
  nls_status_bank i_dut (.clk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .scan_strobe, .field_tx_active, .field_out_inh_active, .field_reconfig,
    .field_scan_err, .field_tx_stop, .field_out_inhibit, .link_word_area_fail, .stn_test_mode, .stn_master,
    .stn_scan_inhibit, .stn_online, .stn_standby, .stn_offline, .stn_down, .stn_online_map,
    .stn_standby_map, .link_area_healthy, .scan_done);
  nls_link_model i_link (.clk, .n, .field_tx_active, .field_out_inh_active, .field_reconfig,
    .field_scan_err, .link_word_area_fail, .stn_test_mode, .stn_master, .stn_scan_inhibit, .stn_online,
    .stn_standby, .stn_offline, .stn_down, .stn_online_map, .stn_standby_map, .link_area_healthy);
  task automatic results;
    if (failures == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask : cmp
  task automatic bus(input logic w, input logic [7:0] i, input logic [15:0] d);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= {i, 2'b00};
    wb_dat_i <= {16'h0000, d};
    do @(posedge clk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o[15:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : bus
  task automatic rc(input logic [7:0] i, input logic [15:0] e);
    bus(1'b0, i, 16'h0000);
    cmp(rd, e);
  endtask : rc
  task automatic t_cmd;
    for (int c = 0; c < 7; c++) begin
      bus(1'b1, NLS_IDX_FIELD_BASE + 8'(2 * c), 16'hFFFF);
      rc(NLS_IDX_FIELD_BASE + 8'(2 * c), NLS_CMD_MASK);
    end
    bus(1'b1, NLS_IDX_FIELD_BASE + 8'h04, 16'h0200);
    rc(NLS_IDX_FIELD_BASE + 8'h04, 16'h0200);
    cmp({2'b00, field_out_inhibit, field_tx_stop}, 16'h3FFB);
  endtask : t_cmd
  task automatic t_status(input logic [9:0] v);
    @(posedge clk);
    n <= v;
    @(posedge clk);
    scan_strobe <= 1'b1;
    @(posedge clk);
    scan_strobe <= 1'b0;
    do @(negedge clk); while (scan_done !== 1'b1);
    bus(1'b1, NLS_IDX_STN_BASE, 16'hFFFF);
    rc(NLS_IDX_STN_BASE, 16'h1031);
    rc(NLS_IDX_STN_BASE + 8'h01, v[1] ? 16'h1031 : 16'hE000);
    rc(NLS_IDX_FIELD_BASE + 8'h01, 16'h0017);
    rc(NLS_IDX_FIELD_BASE + 8'h0D, v[6] ? 16'h0017 : 16'h0000);
    rc(NLS_IDX_ERR_BASE + 8'(v[7:4]), 16'h1 << v[3:0]);
    rc(NLS_IDX_HLT_BASE + 8'(v[9:4]), 16'h1 << v[3:0]);
    rc(NLS_IDX_ONL_BASE + 8'(v[6:4]), 16'h1 << v[3:0]);
    rc(NLS_IDX_STB_BASE + 8'(v[6:4]), ~(16'h1 << v[3:0]));
  endtask : t_status
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 5000) begin
      failures++;
      results();
    end
  end
  initial begin
    {rst_b, wb_cyc_i, wb_stb_i, wb_we_i, scan_strobe} = '0;
    wb_adr_i = '0;
    wb_sel_i = 4'h3;
    wb_dat_i = '0;
    n = '0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    rc(NLS_IDX_FIELD_BASE, NLS_CMD_RESET);
    t_cmd();
    t_status(10'h111);
    t_status(10'h3FF);
    rc(8'hC1, 16'h0000);
    rc(NLS_IDX_SCAN_CTL, 16'h0003);
    results();
  end
endmodule : network_link_status_maps_bench
bind nls_status_bank nls_monitor i_mon (.clk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_dat_o,
  .wb_ack_o, .scan_strobe, .scan_done, .field_tx_stop, .field_out_inhibit);
`default_nettype wire
